// file: verilog/gmsr_regs.sv
// gigabit next-page, role control and role status registers, axi4-lite
//
// Functional notes
// - received next page fields are read-only
// - toggle bit reads as received page toggle
// - acknowledge-2 shows partner compliance with message
// - three-bit test mode, reserved codes, reset normal
// - bit 12 enables manual role configuration
// - bit 11 forces master, only when manual
// - bit 10 multiport, only when automatic
// - bits 9 and 8 advertise gigabit duplex
// - control bits 12:8 reset from strap pins
// - role fault latches until status read
// - status bit 14 shows resolved role
// - local and remote receiver status bits
// - partner abilities valid only with page-received
// - idle error counter in status bits 7:0
// - counter clears on read and resets
// - counter saturates at all ones
// - saturation offered as an interrupt event
// - three 16-bit registers at indices 8-10
// - page-received flag at index 6 latches high
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gmsr_regs #(
   parameter int          ADDR_W     = 8,   // axi address width
   // strapped value of control bits 12:8 for each strap mode
   parameter logic [3:0][4:0] STRAP_CTRL = {5'h03, 5'h03, 5'h1b, 5'h1b}
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // mode strap pins, asynchronous
   input  wire logic [1:0]        mode_strap,
   // events and levels from the negotiation and receive logic
   input  wire logic              page_rx_pulse,
   input  wire logic [15:0]       page_rx_word,
   input  wire logic              role_fault_pulse,
   input  wire logic              role_is_master,
   input  wire logic              local_rx_ok,
   input  wire logic              remote_rx_ok,
   input  wire logic              partner_gig_full_duplex,
   input  wire logic              partner_gig_half_duplex,
   input  wire logic              idle_err_pulse,
   // controls toward the physical layer
   output logic [2:0]             test_mode,
   output logic                   role_manual_en,
   output logic                   role_force_master,
   output logic                   port_multiport,
   output logic                   adv_gig_full,
   output logic                   adv_gig_half,
   output logic                   idle_err_saturated
);

   // whole module state, registered as one
   typedef struct packed {
      // write channel holding
      logic                 aw_held;     // write address captured
      logic [4:0]           aw_idx;      // decoded write index
      logic                 aw_hit;      // write address mapped
      logic                 w_held;      // write data captured
      logic [15:0]          w_data;      // low half of write data
      logic [1:0]           w_strb;      // low two byte lanes
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      // read channel
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      // strap synchroniser and capture
      logic [1:0]           strap_s1;    // first stage, read by s2 only
      logic [1:0]           strap_s2;
      logic [1:0]           strap_mode;  // captured mode
      gmsr_pkg::gmsr_phase_t phase;
      // register contents
      logic [15:0]          np_word;     // last received next page
      logic                 page_rx;     // latched page-received
      logic [2:0]           ctl_tm;      // test mode field
      logic [4:0]           ctl_bits;    // control bits 12:8
      logic                 fault;       // latched role fault
      logic [7:0]           idle_cnt;    // idle error count
      // registered outputs
      logic [2:0]           tm_o;
      logic                 man_en_o;
      logic                 force_m_o;
      logic                 multi_o;
      logic                 adv_fd_o;
      logic                 adv_hd_o;
      logic                 sat_o;
   } gmsr_state_t;

   gmsr_state_t st_ff;   // current state
   gmsr_state_t nxt_st;  // next state

   // map a byte address onto a register index, miss gives IDX_NONE
   function automatic logic [4:0] gmsr_decode(
      input logic [ADDR_W-1:0] addr
   );
      logic [4:0] idx;
      idx = addr[gmsr_pkg::IDX_MSB:gmsr_pkg::IDX_LSB];
      if (addr[ADDR_W-1:gmsr_pkg::IDX_MSB+1] != '0) begin
         gmsr_decode = gmsr_pkg::IDX_NONE;
      end else if (idx == gmsr_pkg::IDX_EXPANSION ||
                   idx == gmsr_pkg::IDX_NEXT_PAGE ||
                   idx == gmsr_pkg::IDX_ROLE_CTRL ||
                   idx == gmsr_pkg::IDX_ROLE_STAT ||
                   idx == gmsr_pkg::IDX_RESET_CTRL) begin
         gmsr_decode = idx;
      end else begin
         gmsr_decode = gmsr_pkg::IDX_NONE;
      end
   endfunction

   // next-state logic for the whole group
   always_comb begin
      logic [4:0]  rd_idx;     // decoded read index
      logic        rd_take;    // read address accepted now
      logic        wr_do;      // write performed now
      logic        soft_rst;   // software reset requested
      logic        logic_rst;  // logic reset requested
      logic        rd_stat;    // status register read now
      logic        rd_exp;     // expansion register read now
      logic [15:0] rd_val;     // 16-bit read value
      logic [4:0]  strap_val;  // strapped control bits
      rd_idx    = gmsr_decode(s_axi_araddr);
      rd_take   = s_axi_arvalid && st_ff.arready;
      wr_do     = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
      soft_rst  = 1'b0;
      logic_rst = 1'b0;
      rd_stat   = rd_take && rd_idx == gmsr_pkg::IDX_ROLE_STAT;
      rd_exp    = rd_take && rd_idx == gmsr_pkg::IDX_EXPANSION;
      rd_val    = 16'h0000;
      strap_val = STRAP_CTRL[st_ff.strap_mode];
      nxt_st    = st_ff;

      // strap pins cross into the clock domain first
      nxt_st.strap_s1 = mode_strap;
      nxt_st.strap_s2 = st_ff.strap_s1;

      // write address: hold until the response is taken
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_idx  = gmsr_decode(s_axi_awaddr);
         nxt_st.aw_hit  = gmsr_decode(s_axi_awaddr) != gmsr_pkg::IDX_NONE;
      end
      // write data: either order with the address is fine
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_held = 1'b1;
         nxt_st.w_data = s_axi_wdata[15:0];
         nxt_st.w_strb = s_axi_wstrb[1:0];
      end

      // perform the write once both halves are in
      if (wr_do) begin
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = st_ff.aw_hit ? gmsr_pkg::RESP_OKAY
                                      : gmsr_pkg::RESP_SLVERR;
         case (st_ff.aw_idx)
            gmsr_pkg::IDX_ROLE_CTRL: begin
               // only the upper byte holds writable bits
               if (st_ff.w_strb[1]) begin
                  nxt_st.ctl_tm   = st_ff.w_data[15:13];
                  nxt_st.ctl_bits = st_ff.w_data[12:8];
               end
            end
            gmsr_pkg::IDX_RESET_CTRL: begin
               // self-clearing strobes, nothing stored
               if (st_ff.w_strb[0]) begin
                  soft_rst  = st_ff.w_data[gmsr_pkg::RST_SOFT];
                  logic_rst = st_ff.w_data[gmsr_pkg::RST_LOGIC];
               end
            end
            default: begin
               // read-only or unmapped: write has no effect
               nxt_st.ctl_tm = st_ff.ctl_tm;
            end
         endcase
      end
      // response handshake frees both channels again
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held  = 1'b0;
      end
      nxt_st.awready = !nxt_st.aw_held;
      nxt_st.wready  = !nxt_st.w_held;

      // read value, reserved bits stay zero
      case (rd_idx)
         gmsr_pkg::IDX_EXPANSION: begin
            rd_val[gmsr_pkg::EXP_PAGE_RX] = st_ff.page_rx;
         end
         gmsr_pkg::IDX_NEXT_PAGE: begin
            // toggle, ack2 and code read as received
            rd_val = st_ff.np_word;
         end
         gmsr_pkg::IDX_ROLE_CTRL: begin
            rd_val[15:13] = st_ff.ctl_tm;
            rd_val[12:8]  = st_ff.ctl_bits;
         end
         gmsr_pkg::IDX_ROLE_STAT: begin
            rd_val[gmsr_pkg::ST_FAULT]  = st_ff.fault;
            rd_val[gmsr_pkg::ST_ROLE]   = role_is_master;
            rd_val[gmsr_pkg::ST_LOC_OK] = local_rx_ok;
            rd_val[gmsr_pkg::ST_REM_OK] = remote_rx_ok;
            // valid only while the page-received flag is up
            rd_val[gmsr_pkg::ST_LP_FD]  = partner_gig_full_duplex;
            rd_val[gmsr_pkg::ST_LP_HD]  = partner_gig_half_duplex;
            rd_val[7:0] = st_ff.idle_cnt;
         end
         default: begin
            // reset control strobes and misses read as zero
            rd_val = 16'h0000;
         end
      endcase

      // read channel, one outstanding read
      if (rd_take) begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid  = 1'b1;
         nxt_st.rdata   = {16'h0000, rd_val};
         nxt_st.rresp   = (rd_idx == gmsr_pkg::IDX_NONE)
                          ? gmsr_pkg::RESP_SLVERR : gmsr_pkg::RESP_OKAY;
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid  = 1'b0;
         nxt_st.arready = 1'b1;
      end

      // received next page captured whole on arrival
      if (page_rx_pulse) begin
         nxt_st.np_word = page_rx_word;
      end
      // page-received latch: clear on read, a new page wins
      if (rd_exp) begin
         nxt_st.page_rx = 1'b0;
      end
      if (page_rx_pulse) begin
         nxt_st.page_rx = 1'b1;
      end

      // role fault latch: clear on status read, new fault wins
      if (rd_stat) begin
         nxt_st.fault = 1'b0;
      end
      if (role_fault_pulse) begin
         nxt_st.fault = 1'b1;
      end

      // idle error counter: read clears, error after clear still counts
      if (rd_stat) begin
         nxt_st.idle_cnt = 8'h00;
      end
      if (idle_err_pulse) begin
         if (rd_stat) begin
            nxt_st.idle_cnt = 8'h01;
         end else if (st_ff.idle_cnt != gmsr_pkg::IDLE_MAX) begin
            nxt_st.idle_cnt = st_ff.idle_cnt + 8'h01;
         end else begin
            // held at all ones so overflow stays visible
            nxt_st.idle_cnt = gmsr_pkg::IDLE_MAX;
         end
      end

      // logic reset only clears the counter, register sets stay
      if (logic_rst || soft_rst) begin
         nxt_st.idle_cnt = 8'h00;
      end
      // software reset returns the group to its strapped defaults
      if (soft_rst) begin
         nxt_st.ctl_tm   = gmsr_pkg::TM_NORMAL;
         nxt_st.ctl_bits = strap_val;
         nxt_st.np_word  = gmsr_pkg::NP_RESET;
         nxt_st.page_rx  = 1'b0;
         nxt_st.fault    = 1'b0;
      end

      // strap capture after reset release, synchroniser settles first
      // pins moving after capture no longer change the defaults
      case (st_ff.phase)
         gmsr_pkg::GMSR_SYNC1: begin
            nxt_st.phase = gmsr_pkg::GMSR_SYNC2;
         end
         gmsr_pkg::GMSR_SYNC2: begin
            nxt_st.phase      = gmsr_pkg::GMSR_RUN;
            nxt_st.strap_mode = st_ff.strap_s2;
            nxt_st.ctl_bits   = STRAP_CTRL[st_ff.strap_s2];
         end
         gmsr_pkg::GMSR_RUN: begin
            nxt_st.phase = gmsr_pkg::GMSR_RUN;
         end
         default: begin
            nxt_st.phase = gmsr_pkg::GMSR_SYNC1;
         end
      endcase

      // reserved test codes fall back to normal operation
      nxt_st.tm_o = (nxt_st.ctl_tm > gmsr_pkg::TM_LAST_VALID)
                    ? gmsr_pkg::TM_NORMAL : nxt_st.ctl_tm;
      // manual role settings apply only while manual is enabled
      nxt_st.man_en_o  = nxt_st.ctl_bits[gmsr_pkg::SB_MAN_EN];
      nxt_st.force_m_o = nxt_st.ctl_bits[gmsr_pkg::SB_MAN_EN] &&
                         nxt_st.ctl_bits[gmsr_pkg::SB_MAN_VAL];
      // port type only matters to automatic resolution
      nxt_st.multi_o   = !nxt_st.ctl_bits[gmsr_pkg::SB_MAN_EN] &&
                         nxt_st.ctl_bits[gmsr_pkg::SB_MULTI];
      nxt_st.adv_fd_o  = nxt_st.ctl_bits[gmsr_pkg::SB_ADV_FD];
      nxt_st.adv_hd_o  = nxt_st.ctl_bits[gmsr_pkg::SB_ADV_HD];
      // level event for the interrupt controller while saturated
      nxt_st.sat_o = nxt_st.idle_cnt == gmsr_pkg::IDLE_MAX;
   end

   // single register stage, synchronous active-low reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_ff            <= '0;
         st_ff.awready    <= 1'b1;
         st_ff.wready     <= 1'b1;
         st_ff.arready    <= 1'b1;
         st_ff.bresp      <= gmsr_pkg::RESP_OKAY;
         st_ff.rresp      <= gmsr_pkg::RESP_OKAY;
         st_ff.phase      <= gmsr_pkg::GMSR_SYNC1;
         // strap synchroniser keeps running through reset, so the
         // capture two edges after release sees settled pins
         st_ff.strap_s1   <= mode_strap;
         st_ff.strap_s2   <= st_ff.strap_s1;
         st_ff.np_word    <= gmsr_pkg::NP_RESET;
         st_ff.ctl_tm     <= gmsr_pkg::TM_NORMAL;
         st_ff.idle_cnt   <= 8'h00;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // every output straight from the state register
   assign s_axi_awready      = st_ff.awready;
   assign s_axi_wready       = st_ff.wready;
   assign s_axi_bvalid       = st_ff.bvalid;
   assign s_axi_bresp        = st_ff.bresp;
   assign s_axi_arready      = st_ff.arready;
   assign s_axi_rvalid       = st_ff.rvalid;
   assign s_axi_rdata        = st_ff.rdata;
   assign s_axi_rresp        = st_ff.rresp;
   assign test_mode          = st_ff.tm_o;
   assign role_manual_en     = st_ff.man_en_o;
   assign role_force_master  = st_ff.force_m_o;
   assign port_multiport     = st_ff.multi_o;
   assign adv_gig_full       = st_ff.adv_fd_o;
   assign adv_gig_half       = st_ff.adv_hd_o;
   assign idle_err_saturated = st_ff.sat_o;

endmodule

// file: verilog/gmsr_pkg.sv
// constants and types shared by the gigabit role register group
package gmsr_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [4:0]  IDX_EXPANSION  = 5'h06; // page-received flag
   localparam logic [4:0]  IDX_NEXT_PAGE  = 5'h08; // received next page
   localparam logic [4:0]  IDX_ROLE_CTRL  = 5'h09; // role control
   localparam logic [4:0]  IDX_ROLE_STAT  = 5'h0a; // role status
   localparam logic [4:0]  IDX_RESET_CTRL = 5'h1f; // soft and logic reset
   localparam logic [4:0]  IDX_NONE       = 5'h00; // decode miss marker
   localparam int          IDX_LSB        = 2;     // word index lsb
   localparam int          IDX_MSB        = 6;     // word index msb

   // received next page fields
   localparam logic [15:0] NP_RESET       = 16'h2000; // message page set
   // role control fields
   localparam int          CTL_TM_LSB     = 13;    // test mode 15:13
   localparam int          CTL_BITS_LSB   = 8;     // strap bits 12:8
   localparam logic [2:0]  TM_NORMAL      = 3'h0;  // normal operation
   localparam logic [2:0]  TM_LAST_VALID  = 3'h4;  // distortion test
   // order of the five strapped bits, msb first
   localparam int          SB_MAN_EN      = 4;     // manual enable
   localparam int          SB_MAN_VAL     = 3;     // manual master
   localparam int          SB_MULTI       = 2;     // multiport
   localparam int          SB_ADV_FD      = 1;     // advertise full
   localparam int          SB_ADV_HD      = 0;     // advertise half
   // role status fields
   localparam int          ST_FAULT       = 15;
   localparam int          ST_ROLE        = 14;
   localparam int          ST_LOC_OK      = 13;
   localparam int          ST_REM_OK      = 12;
   localparam int          ST_LP_FD       = 11;
   localparam int          ST_LP_HD       = 10;
   localparam logic [7:0]  IDLE_MAX       = 8'hff; // saturation value
   // expansion and reset control fields
   localparam int          EXP_PAGE_RX    = 1;
   localparam int          RST_SOFT       = 1;
   localparam int          RST_LOGIC      = 0;

   // bus response codes
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // strap capture phase, gray along the path
   typedef enum logic [1:0] {
      GMSR_SYNC1 = 2'h0,
      GMSR_SYNC2 = 2'h1,
      GMSR_RUN   = 2'h3
   } gmsr_phase_t;
endpackage

// file: verif/gmsr_regs_checker.sv
// concurrent checks on the ports of the gigabit role register group
`timescale 1ns/1ps
module gmsr_regs_checker (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        idle_err_pulse,
   input wire logic        idle_err_saturated,
   input wire logic [2:0]  test_mode,
   input wire logic        role_manual_en,
   input wire logic        role_force_master,
   input wire logic        port_multiport
);
   // one clock domain, so one default clock and disable
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // address and data taken at one edge
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // read address taken
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_wr_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
      else $error("write got no response");
   chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read got no data one cycle later");
   chk_rd_single: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
   chk_rd_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   chk_tm_legal: assert property (test_mode <= 3'h4)
      else $error("reserved test mode reached output");
   chk_force_manual: assert property (
      role_force_master |-> role_manual_en)
      else $error("forced role without manual enable");
   chk_multi_auto: assert property (port_multiport |-> !role_manual_en)
      else $error("port type active in manual mode");
   // with no read or write under way, a saturated count holds
   chk_sat_holds: assert property (
      idle_err_saturated && !s_axi_arvalid && !s_axi_awvalid &&
      s_axi_awready |=> idle_err_saturated)
      else $error("saturated count left all ones");
   chk_sat_cause: assert property (
      $rose(idle_err_saturated) |->
      $past(idle_err_pulse) || $past(idle_err_pulse, 2))
      else $error("saturation without an idle error");
   chk_reset_ctl: assert property (
      $rose(rst_n) |-> test_mode == 3'h0 && !role_manual_en)
      else $error("control outputs not cleared by reset");
endmodule
bind gmsr_regs gmsr_regs_checker u_chk (.*);

// file: verif/gmsr_far_end.sv
// far-side model: negotiation and receive logic feeding events and levels
`timescale 1ns/1ps
module gmsr_far_end (
   input  wire logic        clock,
   output logic             page_rx_pulse,
   output logic [15:0]      page_rx_word,
   output logic             role_fault_pulse,
   output logic             idle_err_pulse,
   output logic             role_is_master,
   output logic             local_rx_ok,
   output logic             remote_rx_ok,
   output logic             partner_gig_full_duplex,
   output logic             partner_gig_half_duplex
);
   // quiet at time zero
   initial begin
      page_rx_pulse = 1'b0;
      page_rx_word = 16'h0;
      role_fault_pulse = 1'b0;
      idle_err_pulse = 1'b0;
      role_is_master = 1'b0;
      local_rx_ok = 1'b0;
      remote_rx_ok = 1'b0;
      partner_gig_full_duplex = 1'b0;
      partner_gig_half_duplex = 1'b0;
   end
   // one page, word only valid with its pulse
   task automatic send_page(input logic [15:0] w);
      @(posedge clock);
      page_rx_pulse <= 1'b1;
      page_rx_word <= w;
      @(posedge clock);
      page_rx_pulse <= 1'b0;
      page_rx_word <= ~w; // stale word is not held
   endtask
   // single role fault event
   task automatic fault();
      @(posedge clock);
      role_fault_pulse <= 1'b1;
      @(posedge clock);
      role_fault_pulse <= 1'b0;
   endtask
   // back-to-back idle errors, one per cycle
   task automatic idle_errs(input int n);
      repeat (n) begin
         @(posedge clock);
         idle_err_pulse <= 1'b1;
      end
      @(posedge clock);
      idle_err_pulse <= 1'b0;
   endtask
   // role, receiver and partner ability levels
   task automatic set_levels(input logic [4:0] v);
      @(posedge clock);
      {role_is_master, local_rx_ok, remote_rx_ok} <= v[4:2];
      {partner_gig_full_duplex, partner_gig_half_duplex} <= v[1:0];
   endtask
endmodule

// file: verif/tb_gmsr_regs.sv
// self-checking bench for the gigabit role register group
`timescale 1ns/1ps
module tb_gmsr_regs;
   // arbitrary strap table, all five bits vary across modes
   localparam logic [3:0][4:0] STRAPS = {5'h15, 5'h0a, 5'h1f, 5'h04};
   logic clock = 1'b0;                   // 250 mhz core clock
   logic rst_n = 1'b0;                   // synchronous, active low
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;      // whole words only
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, mode_strap;
   logic page_rx_pulse, role_fault_pulse, idle_err_pulse;
   logic [15:0] page_rx_word, pg;
   logic role_is_master, local_rx_ok, remote_rx_ok;
   logic partner_gig_full_duplex, partner_gig_half_duplex;
   logic [2:0]  test_mode;
   logic role_manual_en, role_force_master, port_multiport;
   logic adv_gig_full, adv_gig_half, idle_err_saturated;
   logic [4:0]  sb, b;                   // strapped and random ctrl bits
   logic [33:0] bq[$], rq[$];            // notes of expected answers
   int check_count = 0, miscompares = 0, cyc = 0;

   gmsr_regs #(.STRAP_CTRL(STRAPS)) u_dut (.*);
   gmsr_far_end u_far (.*);

   always #2 clock = ~clock;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // a hang counts as a mismatch
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // answers compared against the oldest note
   always @(posedge clock) begin
      if (rst_n && s_axi_bvalid && s_axi_bready)
         chk({32'h0, s_axi_bresp}, bq.pop_front());
      if (rst_n && s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
   end

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] i, input logic [15:0] d,
                     input logic [1:0] r = 2'h0);
      bq.push_back({32'h0, r});
      s_axi_awaddr <= {1'b0, i, 2'h0};
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [4:0] i, input logic [15:0] d,
                     input logic [1:0] r = 2'h0);
      rq.push_back({r, 16'h0, d});
      s_axi_araddr <= {1'b0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask

   // control outputs against mode and the five ctrl bits
   task automatic chk_ctl(input logic [2:0] tm, input logic [4:0] c);
      logic [7:0] o, e;  // seen and expected control outputs
      o = {test_mode, role_manual_en, role_force_master, port_multiport,
           adv_gig_full, adv_gig_half};
      e = {tm, c[4], c[4] & c[3], !c[4] & c[2], c[1], c[0]};
      chk({26'h0, o}, {26'h0, e});
   endtask

   // status word from the live levels
   function automatic logic [15:0] stat(input logic f, input logic [7:0] n);
      return {f, role_is_master, local_rx_ok, remote_rx_ok,
              partner_gig_full_duplex, partner_gig_half_duplex, 2'h0, n};
   endfunction

   initial begin
      void'($urandom(4506));
      mode_strap <= 2'($urandom);
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      sb = STRAPS[mode_strap];
      chk_ctl(3'h0, sb);
      rd(5'h08, 16'h2000);
      rd(5'h09, {3'h0, sb, 8'h0});
      $display("test reset defaults done");
      // every test mode code, random role bits
      for (int m = 0; m < 8; m++) begin
         b = 5'($urandom);
         wr(5'h09, {3'(m), b, 8'hff});
         chk_ctl((m < 5) ? 3'(m) : 3'h0, b);
         if (m < 5) rd(5'h09, {3'(m), b, 8'h0});
      end
      $display("test control modes done");
      wr(5'h08, 16'hffff);
      rd(5'h08, 16'h2000);
      wr(5'h03, 16'hffff, gmsr_pkg::RESP_SLVERR);
      rd(5'h03, 16'h0, gmsr_pkg::RESP_SLVERR);
      $display("test read-only and unmapped done");
      // page first, so partner abilities are valid
      pg = 16'($urandom);
      u_far.send_page(pg);
      u_far.set_levels(5'($urandom));
      u_far.fault();
      rd(5'h08, pg);
      rd(5'h0a, stat(1'b1, 8'h0));
      rd(5'h06, 16'h0002);
      rd(5'h06, 16'h0000);
      rd(5'h0a, stat(1'b0, 8'h0));
      $display("test page and fault done");
      u_far.idle_errs(5);
      rd(5'h0a, stat(1'b0, 8'h05));
      rd(5'h0a, stat(1'b0, 8'h00));
      u_far.idle_errs(300);
      repeat (2) @(posedge clock);
      chk({33'h0, idle_err_saturated}, 34'h1);
      rd(5'h0a, stat(1'b0, 8'hff));
      chk({33'h0, idle_err_saturated}, 34'h0);
      $display("test idle counter done");
      // logic reset clears the count only, soft reset reloads straps
      wr(5'h09, {3'h2, ~sb, 8'h0});
      u_far.idle_errs(3);
      wr(5'h1f, 16'h0001);
      rd(5'h0a, stat(1'b0, 8'h0));
      rd(5'h09, {3'h2, ~sb, 8'h0});
      wr(5'h1f, 16'h0002);
      chk_ctl(3'h0, sb);
      rd(5'h09, {3'h0, sb, 8'h0});
      $display("test resets done");
      report_and_stop();
   end
endmodule
